/* File: swdt_defs.vh */
// Constants for the system watchdog: register offsets, fields, resets, timing.
// Included by every watchdog design file; definitions only.
`ifndef SWDT_DEFS_VH
`define SWDT_DEFS_VH

// Register offsets (word index on the plain register port)
`define SWDT_ADDR_W         4
`define SWDT_REG_CMD        4'h0
`define SWDT_REG_TIMEOUT    4'h1
`define SWDT_REG_STATUS     4'h2
`define SWDT_REG_COUNT      4'h3

// Command register bits (write one to issue)
`define SWDT_CMD_INIT       0
`define SWDT_CMD_START      1
`define SWDT_CMD_SERVICE    2
`define SWDT_CMD_STOP       3

// Timeout register fields
`define SWDT_TICK_W         11
`define SWDT_TICK_LSB       0
`define SWDT_TICK_MSB       10
`define SWDT_UNIT_LSB       16
`define SWDT_UNIT_MSB       23
`define SWDT_UNIT_MINUTE    8'h00
`define SWDT_UNIT_SECOND    8'h01

// Status register bits
`define SWDT_ST_OK          0
`define SWDT_ST_INIT        1
`define SWDT_ST_RUN         2
`define SWDT_ST_EXPIRED     3
`define SWDT_ST_LED         4

// Default timeout after init
`define SWDT_DEF_TICKS      11'h0FF
`define SWDT_DEF_UNIT       8'h01

// Timing: 100 MHz clock
`define SWDT_CLK_HZ         100000000
`define SWDT_SEC_CYCLES     (`SWDT_CLK_HZ)
// Half of the 100 MHz clock, sized to the 27-bit time base counter
`define SWDT_HALF_SEC_CYC   27'h2FAF080
`define SWDT_SEC_PER_MIN    60
`define SWDT_RST_CYCLES     16

`endif

/* File: swdt_tick_gen.v */
// Time base for the watchdog: half-second and one-second strobes.
// Assumes a free-running clock; i_clr restarts the phase.
`timescale 1ns/10ps
`include "swdt_defs.vh"
module swdt_tick_gen #(
  parameter [26:0] HALF_CYCLES = `SWDT_HALF_SEC_CYC
) (
  // Clock, reset and enable
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ce,
  // Control
  input  wire i_clr,
  // Strobes
  output reg  o_half,
  output reg  o_sec
);
  reg [26:0] cnt_r;
  reg        phase_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r   <= 27'h0000000;
      phase_r <= 1'b0;
      o_half  <= 1'b0;
      o_sec   <= 1'b0;
    end else if (i_ce) begin
      o_half <= 1'b0;
      o_sec  <= 1'b0;
      if (i_clr) begin
        cnt_r   <= 27'h0000000;
        phase_r <= 1'b0;
      end else if (cnt_r == HALF_CYCLES - 27'h0000001) begin
        cnt_r   <= 27'h0000000;
        phase_r <= ~phase_r;
        o_half  <= 1'b1;
        o_sec   <= phase_r;
      end else begin
        cnt_r <= cnt_r + 27'h0000001;
      end
    end
  end
endmodule // swdt_tick_gen

/* File: swdt_top.v */
// System watchdog: programmable timeout in minutes or seconds, blinking
// indicator while running, system reset on expiry.
// Assumes host software on a plain register port in the same clock domain.
`timescale 1ns/10ps
`include "swdt_defs.vh"
module swdt_top #(
  parameter [26:0] HALF_SEC_CYCLES = `SWDT_HALF_SEC_CYC
) (
  // Clock, reset, enable
  input  wire                     i_clk,
  input  wire                     i_rst_n,
  input  wire                     i_ce,
  // Register port
  input  wire [`SWDT_ADDR_W-1:0]  i_addr,
  input  wire [31:0]              i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output reg  [31:0]              o_rdata,
  // System side
  output reg                      o_sys_rst,
  output reg                      o_led
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_EXP  = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;

  reg [3:0]              state_r;
  reg [`SWDT_TICK_W-1:0] ticks_r;
  reg [7:0]              unit_r;
  reg [`SWDT_TICK_W-1:0] count_r;
  reg [5:0]              sec_in_min_r;
  reg                    init_r;
  reg                    ok_r;
  reg                    expired_r;
  reg [4:0]              rst_cnt_r;

  wire half_stb;
  wire sec_stb;
  wire wr_cmd = i_wr && (i_addr == `SWDT_REG_CMD);
  wire wr_to  = i_wr && (i_addr == `SWDT_REG_TIMEOUT);
  wire do_init    = wr_cmd && i_wdata[`SWDT_CMD_INIT];
  wire do_start   = wr_cmd && i_wdata[`SWDT_CMD_START];
  wire do_service = wr_cmd && i_wdata[`SWDT_CMD_SERVICE];
  wire do_stop    = wr_cmd && i_wdata[`SWDT_CMD_STOP];
  wire [7:0]              new_unit  = i_wdata[`SWDT_UNIT_MSB:`SWDT_UNIT_LSB];
  wire [`SWDT_TICK_W-1:0] new_ticks = i_wdata[`SWDT_TICK_MSB:`SWDT_TICK_LSB];

  // Unit check used when the timeout register is written
  function unit_ok;
    input [7:0] u;
    begin
      unit_ok = (u == `SWDT_UNIT_MINUTE) || (u == `SWDT_UNIT_SECOND);
    end
  endfunction

  // Range bounds for each unit; ticks outside these are refused at start
  function fmt_ok;
    input [`SWDT_TICK_W-1:0] t;
    input [7:0]              u;
    begin
      if (u == `SWDT_UNIT_MINUTE)
        fmt_ok = (t >= 11'd1) && (t <= 11'd16);
      else if (u == `SWDT_UNIT_SECOND)
        fmt_ok = (t >= 11'd6) && (t <= 11'd1027);
      else
        fmt_ok = 1'b0;
    end
  endfunction

  // Blink phase and unit timing restart together at start and service
  swdt_tick_gen #(
    .HALF_CYCLES (HALF_SEC_CYCLES)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   ((state_r != ST_RUN) || do_service),
    .o_half  (half_stb),
    .o_sec   (sec_stb)
  );

  wire unit_tick = sec_stb && ((unit_r == `SWDT_UNIT_SECOND) ||
                               (sec_in_min_r == 6'd59));

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r      <= ST_IDLE;
      ticks_r      <= `SWDT_DEF_TICKS;
      unit_r       <= `SWDT_DEF_UNIT;
      count_r      <= 11'h000;
      sec_in_min_r <= 6'h00;
      init_r       <= 1'b0;
      ok_r         <= 1'b0;
      expired_r    <= 1'b0;
      rst_cnt_r    <= 5'h00;
      o_sys_rst    <= 1'b0;
      o_led        <= 1'b0;
      o_rdata      <= 32'h00000000;
    end else if (i_ce) begin
      if (do_init) begin
        ticks_r <= `SWDT_DEF_TICKS;
        unit_r  <= `SWDT_DEF_UNIT;
        init_r  <= 1'b1;
        ok_r    <= 1'b1;
      end else if (wr_to) begin
        if (unit_ok(new_unit)) begin
          ticks_r <= new_ticks;
          unit_r  <= new_unit;
          ok_r    <= 1'b1;
        end else begin
          ok_r <= 1'b0;
        end
      end
      case (state_r)
        ST_IDLE: begin
          o_led <= 1'b0;
          if (do_start) begin
            if (fmt_ok(ticks_r, unit_r)) begin
              count_r      <= ticks_r;
              sec_in_min_r <= 6'h00;
              o_led        <= 1'b1;
              ok_r         <= 1'b1;
              state_r      <= ST_RUN;
            end else begin
              ok_r <= 1'b0;
            end
          end
        end
        ST_RUN: begin
          if (do_stop) begin
            o_led   <= 1'b0;
            ok_r    <= 1'b1;
            state_r <= ST_IDLE;
          end else if (do_service) begin
            count_r      <= ticks_r;
            sec_in_min_r <= 6'h00;
            ok_r         <= 1'b1;
          end else begin
            if (half_stb)
              o_led <= ~o_led;
            if (sec_stb)
              sec_in_min_r <= (sec_in_min_r == 6'd59) ? 6'h00 : sec_in_min_r + 6'h01;
            if (unit_tick) begin
              if (count_r == 11'h001) begin
                state_r <= ST_EXP;
              end
              count_r <= count_r - 11'h001;
            end
          end
        end
        ST_EXP: begin
          o_sys_rst <= 1'b1;
          o_led     <= 1'b0;
          expired_r <= 1'b1;
          rst_cnt_r <= 5'h00;
          state_r   <= ST_HOLD;
        end
        ST_HOLD: begin
          // Pulse length fixed so the system sees a clean reset
          if (rst_cnt_r == `SWDT_RST_CYCLES - 1) begin
            o_sys_rst <= 1'b0;
            state_r   <= ST_IDLE;
          end else begin
            rst_cnt_r <= rst_cnt_r + 5'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (i_rd) begin
        case (i_addr)
          `SWDT_REG_TIMEOUT: o_rdata <= {8'h00, unit_r, 5'h00, ticks_r};
          `SWDT_REG_STATUS:  o_rdata <= {27'h0000000, o_led, expired_r,
                                        (state_r == ST_RUN), init_r, ok_r};
          `SWDT_REG_COUNT:   o_rdata <= {21'h000000, count_r};
          default:           o_rdata <= 32'h00000000;
        endcase
      end else begin
        o_rdata <= 32'h00000000;
      end
    end
  end
endmodule // swdt_top

/* File: swdt_asserts.sv */
// Port checker for the watchdog top.
// Assumes one clock, async active-low reset.
`timescale 1ns/10ps
module swdt_chk (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_ce,
  input wire [3:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        o_sys_rst,
  input wire        o_led
);
  default clocking @(posedge i_clk); endclocking
  // Enable low freezes the block, so all checks are disabled while it is low
  default disable iff (!i_rst_n || !i_ce);
  wire rs = i_rd && i_addr == 4'h2;
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
  property p_hole; i_rd && (i_addr == 4'h0 || i_addr > 4'h3) |=> o_rdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole rdata");
  property p_st_led; rs |=> o_rdata[4] == $past(o_led); endproperty
  a_st_led: assert property (p_st_led) else $error("led bit");
  property p_st_rsv; rs |=> o_rdata[31:5] == 27'h0; endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status bits");
  property p_cnt_w; i_rd && i_addr == 4'h3 |=> o_rdata[31:11] == 21'h0; endproperty
  a_cnt_w: assert property (p_cnt_w) else $error("count width");
  property p_rst_hold; $rose(o_sys_rst) |-> o_sys_rst [*8]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset short");
  property p_rst_end; $rose(o_sys_rst) |-> ##16 !o_sys_rst; endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset long");
  property p_stop; i_wr && i_addr == 4'h0 && i_wdata[3] |=> !o_led && !o_sys_rst; endproperty
  a_stop: assert property (p_stop) else $error("stop failed");
endmodule // swdt_chk
bind swdt_top swdt_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sys_rst(o_sys_rst), .o_led(o_led));

/* File: swdt_host.sv */
// Host software model on the register port.
// Assumes read data stands in the cycle after the strobe.
`timescale 1ns/10ps
module swdt_host (
  input  wire        i_clk,
  input  wire [31:0] i_rdata,
  output reg  [3:0]  o_addr = 4'h0,
  output reg  [31:0] o_wdata = 32'h0,
  output reg         o_wr = 1'b0,
  output reg         o_rd = 1'b0
);
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
    end
  endtask
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
    end
  endtask
endmodule // swdt_host

/* File: system_watchdog_timer_bench.sv */
// Watchdog bench: host model drives, integer model checks.
// Half second shortened to five cycles.
`timescale 1ns/10ps
module system_watchdog_timer_bench;
  reg         i_clk = 1'b0;
  reg         i_rst_n = 1'b0;
  reg         pl = 1'b0;
  reg         ce = 1'b1;
  reg  [31:0] lf = 32'h754ED086;
  reg  [31:0] v;
  wire [3:0]  a;
  wire [31:0] wd, rdat;
  wire        wr, rd, srst, led;
  integer     num_errors = 0, checks = 0, cyc = 0, lc = 0, seen = 0;
  integer     n, u, t, mt, mu, ok;
  always #5 i_clk = ~i_clk;
  swdt_host HOST (.i_clk(i_clk), .i_rdata(rdat), .o_addr(a), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  swdt_top #(.HALF_SEC_CYCLES(27'h5)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(a),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_sys_rst(srst), .o_led(led));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] nm, input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rdc(input [3:0] ad, input [31:0] m, input [31:0] e);
    begin
      HOST.rd(ad, v);
      chk({"reg", 8'h30 + ad}, v & m, e);
    end
  endtask
  task wx;
    begin
      t = 0;
      while (srst !== 1'b1 && t < 2000) begin
        @(posedge i_clk);
        t = t + 1;
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    pl <= led;
    if (led !== pl && srst !== 1'b1)
      lc = lc + 1;
    if (srst === 1'b1)
      seen = 1;
    if (cyc == 4000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(4'h2, 32'hFFFFFFFF, 32'h0);
    HOST.wr(4'h0, 32'h1);
    rdc(4'h1, 32'hFFFFFFFF, 32'h000100FF);
    rdc(4'h2, 32'h6, 32'h2);
    mt = 255;
    mu = 1;
    // Valid units, out-of-range ticks, then random bad units
    for (n = 0; n < 6; n = n + 1) begin
      lf = nxt(lf);
      u = n < 4 ? n % 2 : lf[7:0] | 2;
      t = n == 2 ? 17 : n == 3 ? 5 : u == 0 ? 1 + lf[11:8] : u == 1 ? 6 + lf[30:0] % 1022 : lf[26:16];
      HOST.wr(4'h1, u * 65536 + t);
      if (u < 2) begin
        mt = t;
        mu = u;
      end
      rdc(4'h2, 32'h1, u < 2);
      rdc(4'h1, 32'hFFFFFFFF, mu * 65536 + mt);
      HOST.wr(4'h0, 32'h2);
      ok = mu == 0 ? mt > 0 && mt < 17 : mt > 5 && mt < 1028;
      rdc(4'h2, 32'h5, ok * 5);
      if (ok)
        rdc(4'h3, 32'hFFFFFFFF, mt);
      HOST.wr(4'h0, 32'h8);
      rdc(4'h2, 32'h14, 32'h0);
    end
    $display("test program done");
    HOST.wr(4'h1, 32'h00010006);
    HOST.wr(4'h0, 32'h2);
    repeat (45) @(posedge i_clk);
    rdc(4'h3, 32'hFFFFFFFF, 32'h2);
    HOST.wr(4'h0, 32'h4);
    rdc(4'h3, 32'hFFFFFFFF, 32'h6);
    // Enable low must freeze count and time base
    @(posedge i_clk);
    ce <= 1'b0;
    repeat (40) @(posedge i_clk);
    ce <= 1'b1;
    rdc(4'h3, 32'hFFFFFFFF, 32'h6);
    repeat (45) @(posedge i_clk);
    HOST.wr(4'h0, 32'h8);
    repeat (80) @(posedge i_clk);
    chk("srst", seen, 0);
    $display("test service done");
    HOST.wr(4'h0, 32'h2);
    lc = 0;
    wx;
    chk("secs", t / 10, 6);
    chk("led", lc, 1 + 2 * 6);
    repeat (20) @(posedge i_clk);
    rdc(4'h2, 32'hC, 32'h8);
    HOST.wr(4'h1, 32'h00000001);
    HOST.wr(4'h0, 32'h2);
    wx;
    chk("mins", t / 100, 6);
    $display("test expiry done");
    conclude;
  end
endmodule // system_watchdog_timer_bench
